// ### logic/fr_pkg.sv
// Package: constants and carriers for the fault record trigger control
package fr_pkg;

  // Clock and sample rates
  localparam int CLK_HZ         = 25_000_000;
  localparam int SAMPLE_HZ      = 600;
  localparam int CS_PER_S       = 100;
  localparam int SAMPLES_PER_CS = SAMPLE_HZ / CS_PER_S;
  localparam int SAMPLE_DIV     = (CLK_HZ + SAMPLE_HZ / 2) / SAMPLE_HZ;
  localparam int RMS_DECIM      = 12;

  // Setting ranges in units of 10 ms
  localparam logic [8:0] T_MAX_MIN  = 9'h01E;
  localparam logic [8:0] T_MAX_HI   = 9'h1F4;
  localparam logic [8:0] T_MAX_DEF  = 9'h064;
  localparam logic [8:0] T_PP_MIN   = 9'h005;
  localparam logic [8:0] T_PP_HI    = 9'h032;
  localparam logic [8:0] T_PRE_DEF  = 9'h00A;
  localparam logic [8:0] T_POST_DEF = 9'h00A;
  localparam logic [8:0] T_SRC_MIN  = 9'h00A;
  localparam logic [8:0] T_SRC_HI   = 9'h1F4;
  localparam logic [8:0] T_SRC_DEF  = 9'h032;

  // Storage
  localparam int CAP_S        = 5;
  localparam int CAP_SAMPLES  = CAP_S * SAMPLE_HZ;
  localparam int MAX_RECORDS  = 8;
  localparam int PRE_DEPTH    = 50 * SAMPLES_PER_CS;
  localparam int ADDR_W       = 12;
  localparam int PRE_AW       = 9;
  localparam int DATA_W       = 16;

  // Legacy transfer lengths
  localparam logic [11:0] LEGACY_FIXED_LEN = 12'h294;
  localparam logic [11:0] LEGACY_MAX_LEN   = 12'hBB8;

  // Trigger sources
  localparam logic [1:0] SRC_PROT = 2'h0;
  localparam logic [1:0] SRC_BIN  = 2'h1;
  localparam logic [1:0] SRC_KEY  = 2'h2;

  typedef enum logic [1:0] {
    store_on_fault_detect = 2'h0,
    store_on_trip         = 2'h1,
    start_on_trip         = 2'h2
  } init_mode_t;

  typedef struct packed {
    init_mode_t initiation;
    logic       rms_values;
    logic [8:0] t_max_cs;
    logic [8:0] t_pre_cs;
    logic [8:0] t_post_cs;
    logic [8:0] t_bin_cs;
    logic       bin_infinite;
    logic [8:0] t_key_cs;
    logic       legacy_fixed;
    logic       std_protocol;
  } rec_cfg_t;

  localparam rec_cfg_t CFG_DEFAULT = '{
    initiation: store_on_fault_detect, rms_values: 1'b0,
    t_max_cs: T_MAX_DEF, t_pre_cs: T_PRE_DEF, t_post_cs: T_POST_DEF,
    t_bin_cs: T_SRC_DEF, bin_infinite: 1'b0, t_key_cs: T_SRC_DEF,
    legacy_fixed: 1'b1, std_protocol: 1'b0};

  typedef struct packed {
    logic        recording;
    logic [3:0]  count;
    logic [11:0] last_start;
    logic [11:0] last_len;
    logic [11:0] legacy_len;
    logic        legacy_len_valid;
  } rec_stat_t;

endpackage

// ### logic/rec_mem.sv
// Simple dual port sample memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rec_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 3000,
  parameter int AW    = 12
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("rec_mem: depth exceeds address range");
  end

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### logic/fault_record_trigger_control.sv
// Fault recorder trigger, framing and record bookkeeping
`timescale 1ns/1ps
`default_nettype none
module fault_record_trigger_control #(
  parameter int SAMPLE_DIV = fr_pkg::SAMPLE_DIV
) (
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire fr_pkg::rec_cfg_t          cfg,
  input  wire logic                      fault_detect,
  input  wire logic                      trip_cmd,
  input  wire logic                      binary_in,
  input  wire logic                      key_trig,
  input  wire logic                      ui_trig,
  input  wire logic [fr_pkg::DATA_W-1:0] sample_data,
  input  wire logic [fr_pkg::ADDR_W-1:0] rd_addr,
  output var  logic [fr_pkg::DATA_W-1:0] rd_data,
  output var  logic                      sample_tick,
  output var  logic                      rec_done,
  output var  fr_pkg::rec_stat_t         status
);
  localparam int AW  = fr_pkg::ADDR_W;
  localparam int PW  = fr_pkg::PRE_AW;
  localparam int DW  = $clog2(SAMPLE_DIV);
  localparam logic [AW-1:0] CAP = AW'(fr_pkg::CAP_SAMPLES);
  localparam logic [PW-1:0] PRE_D = PW'(fr_pkg::PRE_DEPTH);
  localparam logic [3:0] MAX_REC = 4'(fr_pkg::MAX_RECORDS);

  initial begin
    if (SAMPLE_DIV < 2) $error("SAMPLE_DIV must be at least 2");
    if (fr_pkg::CAP_SAMPLES >= (1 << AW)) $error("capacity too large");
  end

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_COPY   = 5'b00010,
    ST_ACTIVE = 5'b00100,
    ST_POST   = 5'b01000,
    ST_CLOSE  = 5'b10000
  } state_t;

  function automatic logic [AW-1:0] to_samples(input logic [8:0] cs,
                                              input logic [8:0] lo,
                                              input logic [8:0] hi);
    logic [8:0] c;
    c = (cs < lo) ? lo : ((cs > hi) ? hi : cs);
    return AW'(c) * AW'(fr_pkg::SAMPLES_PER_CS);
  endfunction

  function automatic logic [AW-1:0] ring_add(input logic [AW-1:0] a,
                                            input logic [AW-1:0] b,
                                            input logic [AW-1:0] depth);
    logic [AW:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, depth}) begin
      s = s - {1'b0, depth};
    end
    return s[AW-1:0];
  endfunction

  // Pin synchronisers and edge detection
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [4:0] prev_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 5'h00;
    end else begin
      sync1_ff <= {binary_in, trip_cmd, fault_detect};
      sync2_ff <= sync1_ff;
      prev_ff  <= {ui_trig, key_trig, sync2_ff};
    end
  end
  logic fd;
  logic trip;
  logic bin;
  assign fd   = sync2_ff[0];
  assign trip = sync2_ff[1];
  assign bin  = sync2_ff[2];
  logic fd_rise;
  logic trip_rise;
  logic bin_rise;
  logic man_rise;
  assign fd_rise   = fd & ~prev_ff[0];
  assign trip_rise = trip & ~prev_ff[1];
  assign bin_rise  = bin & ~prev_ff[2];
  assign man_rise  = (key_trig & ~prev_ff[3]) | (ui_trig & ~prev_ff[4]);

  // Reference instant and storage criterion
  logic ref_evt;
  logic crit_hold;
  always_comb begin
    case (cfg.initiation)
      fr_pkg::store_on_trip: begin
        ref_evt   = fd_rise;
        crit_hold = trip | fd;
      end
      fr_pkg::start_on_trip: begin
        ref_evt   = trip_rise;
        crit_hold = trip;
      end
      default: begin
        ref_evt   = fd_rise;
        crit_hold = fd;
      end
    endcase
  end

  // Sample rate divider, decimated by twelve for RMS values
  logic [DW-1:0] div_ff;
  logic [3:0]    rms_ff;
  logic          stick_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_ff   <= '0;
      rms_ff   <= 4'h0;
      stick_ff <= 1'b0;
    end else begin
      stick_ff <= 1'b0;
      if (div_ff == DW'(SAMPLE_DIV - 1)) begin
        div_ff <= '0;
        rms_ff <= (rms_ff == 4'(fr_pkg::RMS_DECIM - 1)) ? 4'h0 : rms_ff + 4'h1;
        stick_ff <= !cfg.rms_values || rms_ff == 4'h0;
      end else begin
        div_ff <= div_ff + DW'(1);
      end
    end
  end

  // Clamped settings in samples; RMS stretching comes from the slower tick
  logic [AW-1:0] max_n;
  logic [AW-1:0] pre_n;
  logic [AW-1:0] post_n;
  logic [AW-1:0] bin_n;
  logic [AW-1:0] key_n;
  assign max_n  = to_samples(cfg.t_max_cs, fr_pkg::T_MAX_MIN, fr_pkg::T_MAX_HI);
  assign pre_n  = to_samples(cfg.t_pre_cs, fr_pkg::T_PP_MIN, fr_pkg::T_PP_HI);
  assign post_n = to_samples(cfg.t_post_cs, fr_pkg::T_PP_MIN, fr_pkg::T_PP_HI);
  assign bin_n  = to_samples(cfg.t_bin_cs, fr_pkg::T_SRC_MIN, fr_pkg::T_SRC_HI);
  assign key_n  = to_samples(cfg.t_key_cs, fr_pkg::T_SRC_MIN, fr_pkg::T_SRC_HI);

  // Pre-trigger ring, always filling
  logic [PW-1:0] pre_wp_ff;
  logic [PW-1:0] pre_fill_ff;
  logic [PW-1:0] pre_raddr;
  logic [PW-1:0] pre_base_ff;
  logic [fr_pkg::DATA_W-1:0] pre_rdata;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pre_wp_ff   <= '0;
      pre_fill_ff <= '0;
    end else if (stick_ff) begin
      pre_wp_ff   <= (pre_wp_ff == PRE_D - PW'(1)) ? '0 : pre_wp_ff + PW'(1);
      pre_fill_ff <= (pre_fill_ff == PRE_D) ? PRE_D : pre_fill_ff + PW'(1);
    end
  end

  rec_mem #(.W(fr_pkg::DATA_W), .DEPTH(fr_pkg::PRE_DEPTH), .AW(PW)) u_pre (
    .ref_clk (ref_clk),
    .we      (stick_ff),
    .waddr   (pre_wp_ff),
    .wdata   (sample_data),
    .raddr   (pre_raddr),
    .rdata   (pre_rdata)
  );

  // Record control
  state_t        state_ff;
  logic [1:0]    src_ff;
  logic          keep_ff;
  logic [AW-1:0] rec_start_ff;
  logic [AW-1:0] cur_len_ff;
  logic [AW-1:0] pre_take_ff;
  logic [AW-1:0] copy_idx_ff;
  logic          copy_rd_ff;
  logic [AW-1:0] store_rem_ff;
  logic [AW-1:0] post_rem_ff;
  logic          pend_ff;
  logic [fr_pkg::DATA_W-1:0] hold_ff;
  logic [AW-1:0] head_ff;
  logic [AW-1:0] used_ff;
  logic [2:0]    tail_ff;
  logic [3:0]    count_ff;
  logic [AW-1:0] tab_start_ff [fr_pkg::MAX_RECORDS];
  logic [AW-1:0] tab_len_ff   [fr_pkg::MAX_RECORDS];

  logic          start;
  logic          room_ok;
  logic          drop;
  logic          full_stop;
  logic          live_wr;
  logic          copy_wr;
  logic [AW-1:0] pre_avail;
  logic [AW-1:0] store_cap;
  logic [AW:0]   need;
  assign start     = state_ff == ST_IDLE && (ref_evt || bin_rise || man_rise);
  assign need      = {1'b0, used_ff} + {1'b0, cur_len_ff} + (AW+1)'(2);
  assign room_ok   = need <= {1'b0, CAP};
  // Oldest record gives way to a new one
  assign drop      = count_ff != 4'h0 &&
                     ((start && count_ff == MAX_REC) ||
                      (!room_ok && (state_ff == ST_COPY || state_ff == ST_ACTIVE ||
                                    state_ff == ST_POST)));
  assign full_stop = !room_ok && count_ff == 4'h0 && state_ff != ST_IDLE &&
                     state_ff != ST_CLOSE;
  assign copy_wr   = copy_rd_ff;
  assign live_wr   = pend_ff && room_ok && !copy_rd_ff &&
                     (state_ff == ST_ACTIVE || state_ff == ST_POST);
  assign pre_avail = (AW'(pre_fill_ff) < pre_n) ? AW'(pre_fill_ff) : pre_n;
  // Copy base is frozen at the trigger so the still-filling ring cannot shift it
  assign pre_raddr = PW'(ring_add(AW'(pre_base_ff), copy_idx_ff, AW'(PRE_D)));
  assign store_cap = (src_ff == fr_pkg::SRC_BIN && cfg.bin_infinite) ? max_n :
                     (src_ff == fr_pkg::SRC_BIN) ? ((bin_n < max_n) ? bin_n : max_n) :
                     ((key_n < max_n) ? key_n : max_n);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
      hold_ff <= '0;
    end else if (stick_ff) begin
      pend_ff <= 1'b1;
      hold_ff <= sample_data;
    end else if (live_wr || state_ff == ST_IDLE) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff     <= ST_IDLE;
      src_ff       <= fr_pkg::SRC_PROT;
      keep_ff      <= 1'b0;
      rec_start_ff <= '0;
      cur_len_ff   <= '0;
      pre_take_ff  <= '0;
      pre_base_ff  <= '0;
      copy_idx_ff  <= '0;
      copy_rd_ff   <= 1'b0;
      store_rem_ff <= '0;
      post_rem_ff  <= '0;
    end else begin
      copy_rd_ff <= 1'b0;
      if (copy_wr || live_wr) begin
        cur_len_ff <= cur_len_ff + AW'(1);
      end
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            src_ff       <= ref_evt ? fr_pkg::SRC_PROT :
                            (bin_rise ? fr_pkg::SRC_BIN : fr_pkg::SRC_KEY);
            keep_ff      <= ref_evt ? cfg.initiation != fr_pkg::store_on_trip : 1'b1;
            rec_start_ff <= head_ff;
            cur_len_ff   <= '0;
            pre_take_ff  <= pre_avail;
            pre_base_ff  <= PW'(ring_add(AW'(pre_wp_ff), AW'(PRE_D) - pre_avail,
                                         AW'(PRE_D)));
            copy_idx_ff  <= '0;
            state_ff     <= ST_COPY;
          end
        end
        ST_COPY: begin
          if (full_stop) begin
            state_ff <= ST_CLOSE;
          end else if (copy_idx_ff == pre_take_ff) begin
            store_rem_ff <= store_cap;
            state_ff     <= ST_ACTIVE;
          end else if (room_ok && !copy_rd_ff) begin
            copy_rd_ff  <= 1'b1;
            copy_idx_ff <= copy_idx_ff + AW'(1);
          end
        end
        ST_ACTIVE: begin
          if (src_ff == fr_pkg::SRC_PROT && trip) begin
            keep_ff <= 1'b1;
          end
          if (full_stop) begin
            state_ff <= ST_CLOSE;
          end else if (live_wr) begin
            store_rem_ff <= store_rem_ff - AW'(1);
            post_rem_ff  <= post_n;
            if (src_ff == fr_pkg::SRC_PROT) begin
              if (cur_len_ff + AW'(1) >= max_n) begin
                state_ff <= ST_CLOSE;
              end else if (!crit_hold) begin
                state_ff <= ST_POST;
              end
            end else if (src_ff == fr_pkg::SRC_BIN && cfg.bin_infinite) begin
              if (!bin || store_rem_ff <= AW'(1)) begin
                state_ff <= ST_POST;
              end
            end else if (store_rem_ff <= AW'(1)) begin
              state_ff <= ST_POST;
            end
          end
        end
        ST_POST: begin
          if (full_stop) begin
            state_ff <= ST_CLOSE;
          end else if (live_wr) begin
            post_rem_ff <= post_rem_ff - AW'(1);
            if (post_rem_ff <= AW'(1) ||
                (src_ff == fr_pkg::SRC_PROT && cur_len_ff + AW'(1) >= max_n)) begin
              state_ff <= ST_CLOSE;
            end
          end
        end
        ST_CLOSE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  rec_mem #(.W(fr_pkg::DATA_W), .DEPTH(fr_pkg::CAP_SAMPLES), .AW(AW)) u_store (
    .ref_clk (ref_clk),
    .we      (copy_wr || live_wr),
    .waddr   (ring_add(rec_start_ff, cur_len_ff, CAP)),
    .wdata   (copy_wr ? pre_rdata : hold_ff),
    .raddr   (rd_addr),
    .rdata   (rd_data)
  );

  // Record table: commit on close, drop the oldest on demand
  logic commit;
  assign commit = state_ff == ST_CLOSE && keep_ff && cur_len_ff != '0;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      head_ff  <= '0;
      used_ff  <= '0;
      tail_ff  <= 3'h0;
      count_ff <= 4'h0;
      for (int i = 0; i < fr_pkg::MAX_RECORDS; i++) begin
        tab_start_ff[i] <= '0;
        tab_len_ff[i]   <= '0;
      end
    end else if (commit) begin
      tab_start_ff[tail_ff + count_ff[2:0]] <= rec_start_ff;
      tab_len_ff[tail_ff + count_ff[2:0]]   <= cur_len_ff;
      count_ff <= count_ff + 4'h1;
      used_ff  <= used_ff + cur_len_ff;
      head_ff  <= ring_add(rec_start_ff, cur_len_ff, CAP);
    end else if (drop) begin
      used_ff  <= used_ff - tab_len_ff[tail_ff];
      tail_ff  <= tail_ff + 3'h1;
      count_ff <= count_ff - 4'h1;
    end
  end

  // Status outputs
  logic [AW-1:0] legacy_n;
  assign legacy_n = cfg.legacy_fixed ? fr_pkg::LEGACY_FIXED_LEN :
                    ((cur_len_ff > fr_pkg::LEGACY_MAX_LEN) ? fr_pkg::LEGACY_MAX_LEN :
                     cur_len_ff);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      status      <= '0;
      rec_done    <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick      <= stick_ff;
      rec_done         <= commit;
      status.recording <= state_ff != ST_IDLE;
      status.count     <= commit ? count_ff + 4'h1 : (drop ? count_ff - 4'h1 : count_ff);
      status.legacy_len_valid <= !cfg.std_protocol;
      if (commit) begin
        status.last_start <= rec_start_ff;
        status.last_len   <= cur_len_ff;
        status.legacy_len <= cfg.std_protocol ? '0 : legacy_n;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/fault_record_trigger_control_monitor.sv
// Checker for the fault record trigger control ports
`timescale 1ns/1ps
`default_nettype none
module fault_record_trigger_control_monitor #(
  parameter int SAMPLE_DIV = 4
) (
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire fr_pkg::rec_cfg_t  cfg,
  input wire logic              key_trig,
  input wire logic              sample_tick,
  input wire logic              rec_done,
  input wire fr_pkg::rec_stat_t status
);
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  int   gap_ff;
  logic rms_ff;
  logic armed_ff;

  // Gap is only trusted once a tick has passed since the mode last changed
  always_ff @(posedge ref_clk) begin
    gap_ff <= sample_tick ? 0 : gap_ff + 1;
    rms_ff <= cfg.rms_values;
    if (!nrst || cfg.rms_values != rms_ff) begin
      armed_ff <= 1'b0;
    end else if (sample_tick) begin
      armed_ff <= 1'b1;
    end
  end

  reset_clear_a: assert property (disable iff (1'b0) !nrst |=> !rec_done && !sample_tick
    && !status.recording && status.count == 4'h0)
    else $error("outputs not cleared by reset");
  tick_period_a: assert property (sample_tick && armed_ff |-> gap_ff ==
    (cfg.rms_values ? 12 * SAMPLE_DIV - 1 : SAMPLE_DIV - 1))
    else $error("sample tick period wrong");
  done_pulse_a: assert property (rec_done |=> !rec_done)
    else $error("record done longer than one cycle");
  trig_answer_a: assert property ($rose(key_trig) && !status.recording
    |-> ##[1:4] status.recording)
    else $error("key edge did not start a record");
  done_idle_a: assert property (rec_done |-> ##[0:2] !status.recording)
    else $error("recording still set after commit");
  count_limit_a: assert property (status.count <= 4'h8)
    else $error("record count above eight");
  legacy_fixed_a: assert property (rec_done && !cfg.std_protocol && cfg.legacy_fixed
    |=> status.legacy_len == fr_pkg::LEGACY_FIXED_LEN && status.legacy_len_valid)
    else $error("fixed legacy length wrong");
  legacy_var_a: assert property (rec_done && !cfg.std_protocol && !cfg.legacy_fixed
    |=> status.legacy_len == ((status.last_len > fr_pkg::LEGACY_MAX_LEN) ?
    fr_pkg::LEGACY_MAX_LEN : status.last_len))
    else $error("variable legacy length wrong");
  legacy_std_a: assert property (rec_done && cfg.std_protocol
    |=> status.legacy_len == 12'h000 && !status.legacy_len_valid)
    else $error("legacy length used with standard protocol");

  cover property (rec_done);
  cover property (sample_tick && cfg.rms_values);
  cover property (status.count == 4'h8);
endmodule
bind fault_record_trigger_control fault_record_trigger_control_monitor #(
  .SAMPLE_DIV(SAMPLE_DIV)
) mon (
  .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .key_trig(key_trig),
  .sample_tick(sample_tick), .rec_done(rec_done), .status(status)
);
`default_nettype wire

// ### tb/prot_model.sv
// Protection pickup and trip model driving the recorder criteria
`timescale 1ns/1ps
`default_nettype none
module prot_model #(
  parameter int TRIP_DELAY = 8
) (
  input  wire logic ref_clk,
  input  wire logic go,
  input  wire logic with_trip,
  output var  logic fault_detect,
  output var  logic trip_cmd
);
  int delay_ff = 0;
  initial begin
    fault_detect = 1'b0;
    trip_cmd = 1'b0;
  end
  // Hold spans come from the bench already scaled to the system frequency
  always @(posedge ref_clk) begin
    fault_detect <= go;
    delay_ff <= go ? delay_ff + 1 : 0;
    trip_cmd <= go && with_trip && delay_ff >= TRIP_DELAY;
  end
endmodule
`default_nettype wire

// ### tb/fault_record_trigger_control_bench.sv
// Testbench for the fault record trigger control
`timescale 1ns/1ps
`default_nettype none
module fault_record_trigger_control_bench;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  fr_pkg::rec_cfg_t  cfg;
  logic              binary_in = 1'b0;
  logic              key_trig = 1'b0;
  logic              ui_trig = 1'b0;
  logic              go = 1'b0;
  logic              with_trip = 1'b0;
  logic [15:0]       sample_data = 16'h0000;
  logic [15:0]       rd_data;
  logic [11:0]       rd_addr = 12'h000;
  logic              sample_tick;
  logic              rec_done;
  logic              fault_detect;
  logic              trip_cmd;
  fr_pkg::rec_stat_t status;
  int                dones = 0;
  int                fail_count = 0;
  int                total_checks = 0;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) sample_data <= sample_data + 16'h0001;
  always @(posedge ref_clk) if (rec_done === 1'b1) dones <= dones + 1;

  prot_model prot (.ref_clk(ref_clk), .go(go), .with_trip(with_trip),
    .fault_detect(fault_detect), .trip_cmd(trip_cmd));

  fault_record_trigger_control #(.SAMPLE_DIV(4)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .fault_detect(fault_detect),
    .trip_cmd(trip_cmd), .binary_in(binary_in), .key_trig(key_trig), .ui_trig(ui_trig),
    .sample_data(sample_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .sample_tick(sample_tick), .rec_done(rec_done), .status(status));

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Source 0 key, 1 interface, 2 binary input, 3 protection; held n cycles
  task automatic fire(int src, int n);
    @(posedge ref_clk);
    case (src)
      0: key_trig <= 1'b1;
      1: ui_trig <= 1'b1;
      2: binary_in <= 1'b1;
      default: go <= 1'b1;
    endcase
    cyc(n);
    key_trig <= 1'b0;
    ui_trig <= 1'b0;
    binary_in <= 1'b0;
    go <= 1'b0;
  endtask

  // Waits long enough to refill the pre-trigger history, then records
  task automatic record(string what, int src, int n, int again, logic [11:0] exp);
    int d0;
    int k;
    cyc(1600);
    d0 = dones;
    fire(src, n);
    if (again != 0) begin
      cyc(100);
      fire(0, 1);
    end
    k = 0;
    while (dones == d0 && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    cyc(2);
    check(what, exp, (k < 20000) ? status.last_len : 12'hFFF);
  endtask

  initial begin
    int d0;
    cfg = fr_pkg::CFG_DEFAULT;
    cfg.t_max_cs = 9'h01E;
    cfg.t_pre_cs = 9'h005;
    cfg.t_post_cs = 9'h005;
    cfg.t_bin_cs = 9'h00A;
    cfg.t_key_cs = 9'h00A;
    cyc(4);
    nrst <= 1'b1;
    record("key length", 0, 1, 0, 12'h078);
    check("legacy fixed", 12'h294, status.legacy_len);
    d0 = int'(rd_data);
    rd_addr <= 12'h001;
    cyc(2);
    check("sample spacing", 12'h004, 12'(rd_data - 16'(d0)));
    record("interface length", 1, 1, 1, 12'h078);
    check("record count", 12'h002, {8'h00, status.count});
    @(posedge ref_clk);
    cfg.t_key_cs <= 9'h032;
    cfg.legacy_fixed <= 1'b0;
    record("key capped", 0, 1, 0, 12'h0F0);
    check("legacy variable", 12'h0F0, status.legacy_len);
    record("binary length", 2, 40, 0, 12'h078);
    cfg.bin_infinite <= 1'b1;
    record("binary infinite", 2, 2000, 0, 12'h0F0);
    record("fault capped", 3, 4000, 0, 12'h0B4);
    cfg.initiation <= fr_pkg::store_on_trip;
    cyc(1600);
    d0 = dones;
    fire(3, 400);
    cyc(1500);
    check("no trip commit", 12'(d0), 12'(dones));
    with_trip <= 1'b1;
    record("trip storage", 3, 4000, 0, 12'h0B4);
    cfg.initiation <= fr_pkg::start_on_trip;
    record("trip start", 3, 4000, 0, 12'h0B4);
    cfg.std_protocol <= 1'b1;
    record("standard key", 0, 1, 0, 12'h0F0);
    check("legacy unused", 12'h000, status.legacy_len);
    check("count full", 12'h008, {8'h00, status.count});
    cfg.rms_values <= 1'b1;
    record("rms key", 0, 1, 0, 12'h0F0);
    complete_run();
  end

  initial begin
    cyc(100000);
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    complete_run();
  end
endmodule
`default_nettype wire
